/* ct_pkg.sv */
// Constants shared by the current transformer circuit supervision block.
// Assumes a 40 MHz clock and currents scaled in hundredths of nominal.
package ct_pkg;
  // Register byte offsets
  localparam logic [5:0] OFF_CTRL   = 6'h00;
  localparam logic [5:0] OFF_HIGH   = 6'h04;
  localparam logic [5:0] OFF_LOW    = 6'h08;
  localparam logic [5:0] OFF_RATIO  = 6'h0C;
  localparam logic [5:0] OFF_SEQ    = 6'h10;
  localparam logic [5:0] OFF_SUMD   = 6'h14;
  localparam logic [5:0] OFF_DELAY  = 6'h18;
  localparam logic [5:0] OFF_STATUS = 6'h1C;
  localparam logic [5:0] OFF_DMAG   = 6'h20;
  localparam logic [5:0] OFF_DANG   = 6'h24;
  localparam logic [5:0] OFF_OFFSET = 6'h28;
  // Control field positions
  localparam int CTRL_COMP_BIT = 16;
  // Operating modes
  localparam logic [2:0] MODE_ON   = 3'h1;
  localparam logic [2:0] MODE_BLK  = 3'h2;
  localparam logic [2:0] MODE_TEST = 3'h3;
  localparam logic [2:0] MODE_TBLK = 3'h4;
  localparam logic [2:0] MODE_OFF  = 3'h5;
  // Forcing and residual selection
  localparam logic [1:0] FORCE_NORMAL = 2'h0;
  localparam logic [1:0] FORCE_ALARM  = 2'h1;
  localparam logic [1:0] FORCE_BLOCK  = 2'h2;
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_ONE  = 2'h1;
  localparam logic [1:0] RES_TWO  = 2'h2;
  // Reset values of the settings
  localparam logic [15:0] RST_HIGH  = 16'h0078;
  localparam logic [15:0] RST_LOW   = 16'h000A;
  localparam logic [15:0] RST_RATIO = 16'h03E8;
  localparam logic [15:0] RST_SEQ   = 16'h1324;
  localparam logic [15:0] RST_SUMD  = 16'h000A;
  localparam logic [18:0] RST_DELAY = 19'h0_0064;
  // Ratio scale, hysteresis in percent, angle span
  localparam logic [31:0] RATIO_FULL = 32'h0000_2710;
  localparam int PCT     = 100;
  localparam int HYST_LO = 97;
  localparam int HYST_HI = 103;
  localparam logic signed [18:0] ANG_FULL = 19'sh0_8CA0;
  // Delay step time and its cycle count
  localparam int STEP_US  = 5000;
  localparam int CLK_NS   = 25;
  localparam int STEP_CYC = STEP_US * 1000 / CLK_NS;
endpackage

/* cmp_hyst.sv */
// Threshold comparator with reset hysteresis relative to the threshold.
// Combinational; the caller holds the previous state.
`timescale 1ns/10ps
`default_nettype none
module cmp_hyst #(
  parameter int W     = 32,
  parameter bit UNDER = 1'b0
) (
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] thr,
  input  wire logic         active,
  output logic              active_next
);
  localparam int X = W + 8;
  logic [X-1:0] v100;
  logic [X-1:0] t100;
  logic [X-1:0] t97;
  logic [X-1:0] t103;

  // Scaled by 100 so no division is needed
  always_comb begin
    v100 = X'(value) * X'(ct_pkg::PCT);
    t100 = X'(thr) * X'(ct_pkg::PCT);
    t97  = X'(thr) * X'(ct_pkg::HYST_LO);
    t103 = X'(thr) * X'(ct_pkg::HYST_HI);
    if (UNDER) begin
      active_next = active ? (v100 < t103) : (v100 < t100);
    end else begin
      active_next = active ? (v100 > t97) : (v100 > t100);
    end
  end
endmodule
`default_nettype wire

/* sync3.sv */
// Three-stage synchroniser for a pin level.
// Output follows once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module sync3 (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic [2:0] q;
    logic       o;
  } sync_state_t;
  sync_state_t s;
  sync_state_t n;

  always_comb begin
    n = s;
    n.q = {s.q[1:0], din};
    if (s.q[1] == s.q[2]) begin
      n.o = s.q[2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign dout = s.o;
endmodule
`default_nettype wire

/* ct_circuit_supervision.sv */
// Current transformer circuit supervision with Avalon-MM registers.
// Assumes measurements arrive on clk with a meas_valid strobe per cycle.
// Operation
// - Five operating modes, mode shown read-only
// - Forcing overrides outputs to alarm or blocked
// - Residual source: none, channel one, two
// - Polarity adds or subtracts residual channel
// - Compensation stores calculated residual as offset
// - Hysteresis 97/103 percent of threshold
// - Any phase above high limit: no activation
// - Low limit condition needed for activation
// - Min/max phase ratio below ratio setting
// - Negative/positive sequence ratio above setting
// - Residual difference tested against threshold
// - Alarm after settable persisting delay
// - Start only while blocking inactive
// - Binary pick-up acts without added delay
// - Difference magnitude readable
// - Difference angle readable
// - Static settings untouched by group switching
// - All conditions together before timer runs
// - Block sampled each processing cycle
`timescale 1ns/10ps
`default_nettype none
module ct_circuit_supervision #(
  parameter int STEP_CYC = ct_pkg::STEP_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [5:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               meas_valid,
  input  wire logic [15:0]        phase_a_rms,
  input  wire logic [15:0]        phase_b_rms,
  input  wire logic [15:0]        phase_c_rms,
  input  wire logic [15:0]        pos_seq,
  input  wire logic [15:0]        neg_seq,
  input  wire logic signed [15:0] calc_re,
  input  wire logic signed [15:0] calc_im,
  input  wire logic signed [16:0] calc_ang,
  input  wire logic signed [15:0] residual_channel_one_re,
  input  wire logic signed [15:0] residual_channel_one_im,
  input  wire logic signed [16:0] residual_channel_one_ang,
  input  wire logic signed [15:0] residual_channel_two_re,
  input  wire logic signed [15:0] residual_channel_two_im,
  input  wire logic signed [16:0] residual_channel_two_ang,
  input  wire logic               block_in,
  input  wire logic               binary_pickup,
  output logic                    alarm,
  output logic                    blocked,
  output logic                    start
);
  typedef struct packed {
    logic [2:0]  mode;
    logic        force_en;
    logic [1:0]  force_sel;
    logic [1:0]  res_sel;
    logic        pol;
    logic        bin_sel;
    logic [15:0] high;
    logic [15:0] low;
    logic [15:0] ratio;
    logic [15:0] seq;
    logic [15:0] sumd;
    logic [18:0] delay;
    logic [2:0]  behav;
    logic [2:0]  hi_st;
    logic [2:0]  lo_st;
    logic        mm_st;
    logic        seq_st;
    logic        res_st;
    logic        blk;
    logic        start;
    logic        blocked;
    logic        alarm;
    logic        out_alarm;
    logic        out_blocked;
    logic [31:0] presc;
    logic [18:0] steps;
    logic [15:0] diff_mag;
    logic [18:0] ang_diff;
    logic [15:0] off_re;
    logic [15:0] off_im;
    logic        ack;
    logic [31:0] rdata;
  } sup_state_t;

  sup_state_t s;
  sup_state_t n;
  logic [15:0] ph [3];
  logic [2:0]  hi_d;
  logic [2:0]  lo_d;
  logic        mm_d;
  logic        seq_d;
  logic        res_d;
  logic        blk_sync;
  logic        pickup;
  logic [15:0] ph_min;
  logic [15:0] ph_max;
  logic signed [17:0] cre;
  logic signed [17:0] cim;
  logic signed [17:0] rre;
  logic signed [17:0] rim;
  logic signed [18:0] ang;
  logic [17:0] mag;

  function automatic logic [17:0] abs_f(input logic signed [17:0] a);
    abs_f = a[17] ? 18'(-a) : 18'(a);
  endfunction

  // Max plus 3/8 min: within about 7 percent of the true length
  function automatic logic [17:0] mag_f(input logic signed [17:0] a,
                                        input logic signed [17:0] b);
    logic [17:0] x;
    logic [17:0] y;
    x = abs_f(a);
    y = abs_f(b);
    if (x < y) begin
      x = abs_f(b);
      y = abs_f(a);
    end
    mag_f = x + 18'(({2'b00, y} * 20'h0_0003) >> 3);
  endfunction

  function automatic logic [31:0] merge_f(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
    merge_f = old;
  endfunction

  assign ph[0] = phase_a_rms;
  assign ph[1] = phase_b_rms;
  assign ph[2] = phase_c_rms;

  sync3 u_block_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (block_in),
    .dout (blk_sync)
  );

  generate
    for (genvar i = 0; i < 3; i++) begin : g_phase
      cmp_hyst #(.W(32), .UNDER(1'b0)) u_high (
        .value       ({16'h0000, ph[i]}),
        .thr         ({16'h0000, s.high}),
        .active      (s.hi_st[i]),
        .active_next (hi_d[i])
      );
      cmp_hyst #(.W(32), .UNDER(1'b0)) u_low (
        .value       ({16'h0000, ph[i]}),
        .thr         ({16'h0000, s.low}),
        .active      (s.lo_st[i]),
        .active_next (lo_d[i])
      );
    end
  endgenerate

  always_comb begin
    ph_min = ph[0];
    ph_max = ph[0];
    for (int i = 1; i < 3; i++) begin
      ph_min = (ph[i] < ph_min) ? ph[i] : ph_min;
      ph_max = (ph[i] > ph_max) ? ph[i] : ph_max;
    end
  end

  cmp_hyst #(.W(32), .UNDER(1'b1)) u_minmax (
    .value       (32'(ph_min) * ct_pkg::RATIO_FULL),
    .thr         (32'(s.ratio) * 32'(ph_max)),
    .active      (s.mm_st),
    .active_next (mm_d)
  );

  cmp_hyst #(.W(32), .UNDER(1'b0)) u_seq (
    .value       (32'(neg_seq) * ct_pkg::RATIO_FULL),
    .thr         (32'(s.seq) * 32'(pos_seq)),
    .active      (s.seq_st),
    .active_next (seq_d)
  );

  cmp_hyst #(.W(32), .UNDER(1'b0)) u_res (
    .value       ({16'h0000, s.diff_mag}),
    .thr         ({16'h0000, s.sumd}),
    .active      (s.res_st),
    .active_next (res_d)
  );

  // Residual vector path; sum difference of phases and residual
  always_comb begin
    rre = '0;
    rim = '0;
    ang = 19'(calc_ang);
    case (s.res_sel)
      ct_pkg::RES_ONE: begin
        rre = 18'(residual_channel_one_re);
        rim = 18'(residual_channel_one_im);
        ang = 19'(calc_ang) - 19'(residual_channel_one_ang);
      end
      ct_pkg::RES_TWO: begin
        rre = 18'(residual_channel_two_re);
        rim = 18'(residual_channel_two_im);
        ang = 19'(calc_ang) - 19'(residual_channel_two_ang);
      end
      default: begin
      end
    endcase
    if (ang > ct_pkg::ANG_FULL) begin
      ang = ang - ct_pkg::ANG_FULL;
    end else if (ang < -ct_pkg::ANG_FULL) begin
      ang = ang + ct_pkg::ANG_FULL;
    end
    cre = 18'(calc_re) - 18'($signed(s.off_re));
    cim = 18'(calc_im) - 18'($signed(s.off_im));
    cre = s.pol ? cre - rre : cre + rre;
    cim = s.pol ? cim - rim : cim + rim;
    mag = mag_f(cre, cim);
  end

  // All conditions together; latest evaluated comparator states
  always_comb begin
    if (s.bin_sel) begin
      pickup = binary_pickup;
    end else begin
      pickup = ~|s.hi_st & |s.lo_st & ~&s.lo_st & s.mm_st & s.seq_st
             & ((s.res_sel == ct_pkg::RES_NONE) | s.res_st);
    end
  end

  always_comb begin
    logic [31:0] w;
    logic        hit;
    logic        mode_blk;
    logic        mode_run;
    w = '0;
    hit = 1'b0;
    mode_blk = 1'b0;
    mode_run = 1'b0;
    n = s;
    hit = avs_write & s.ack;
    n.ack = (avs_read | avs_write) & ~s.ack;
    if (hit) begin
      case (avs_address)
        ct_pkg::OFF_CTRL: begin
          // Static settings live apart from any setting group
          w = merge_f({22'h0, s.bin_sel, s.pol, s.res_sel, s.force_sel,
                       s.force_en, s.mode}, avs_writedata, avs_byteenable);
          {n.bin_sel, n.pol, n.res_sel, n.force_sel, n.force_en, n.mode}
            = w[9:0];
          if (w[ct_pkg::CTRL_COMP_BIT] & avs_byteenable[2]) begin
            n.off_re = calc_re;
            n.off_im = calc_im;
          end
        end
        ct_pkg::OFF_HIGH: begin
          w = merge_f({16'h0, s.high}, avs_writedata, avs_byteenable);
          n.high = w[15:0];
        end
        ct_pkg::OFF_LOW: begin
          w = merge_f({16'h0, s.low}, avs_writedata, avs_byteenable);
          n.low = w[15:0];
        end
        ct_pkg::OFF_RATIO: begin
          w = merge_f({16'h0, s.ratio}, avs_writedata, avs_byteenable);
          n.ratio = w[15:0];
        end
        ct_pkg::OFF_SEQ: begin
          w = merge_f({16'h0, s.seq}, avs_writedata, avs_byteenable);
          n.seq = w[15:0];
        end
        ct_pkg::OFF_SUMD: begin
          w = merge_f({16'h0, s.sumd}, avs_writedata, avs_byteenable);
          n.sumd = w[15:0];
        end
        ct_pkg::OFF_DELAY: begin
          w = merge_f({13'h0, s.delay}, avs_writedata, avs_byteenable);
          n.delay = w[18:0];
        end
        default: begin
        end
      endcase
    end
    if ((avs_read | avs_write) & ~s.ack) begin
      case (avs_address)
        ct_pkg::OFF_CTRL: n.rdata = {22'h0, s.bin_sel, s.pol, s.res_sel,
                                     s.force_sel, s.force_en, s.mode};
        ct_pkg::OFF_HIGH:   n.rdata = {16'h0, s.high};
        ct_pkg::OFF_LOW:    n.rdata = {16'h0, s.low};
        ct_pkg::OFF_RATIO:  n.rdata = {16'h0, s.ratio};
        ct_pkg::OFF_SEQ:    n.rdata = {16'h0, s.seq};
        ct_pkg::OFF_SUMD:   n.rdata = {16'h0, s.sumd};
        ct_pkg::OFF_DELAY:  n.rdata = {13'h0, s.delay};
        ct_pkg::OFF_STATUS: n.rdata = {19'h0, s.res_st, s.seq_st, s.mm_st,
                                       ~&s.lo_st, |s.lo_st, |s.hi_st,
                                       pickup, s.start, s.out_blocked,
                                       s.out_alarm, s.behav};
        ct_pkg::OFF_DMAG:   n.rdata = {16'h0, s.diff_mag};
        ct_pkg::OFF_DANG:   n.rdata = 32'($signed(s.ang_diff));
        ct_pkg::OFF_OFFSET: n.rdata = {s.off_im, s.off_re};
        default:            n.rdata = '0;
      endcase
    end
    n.behav = s.mode;
    if (meas_valid) begin
      n.blk    = blk_sync;
      n.hi_st  = hi_d;
      n.lo_st  = lo_d;
      n.mm_st  = mm_d;
      n.seq_st = seq_d;
      n.res_st = res_d;
      n.diff_mag = (|mag[17:16]) ? 16'hFFFF : mag[15:0];
      n.ang_diff = ang;
    end
    // Unknown mode codes are treated as Off
    mode_blk = (n.mode == ct_pkg::MODE_BLK) | (n.mode == ct_pkg::MODE_TBLK);
    mode_run = mode_blk | (n.mode == ct_pkg::MODE_ON)
             | (n.mode == ct_pkg::MODE_TEST);
    n.start   = mode_run & pickup & ~(n.blk | mode_blk);
    n.blocked = mode_run & pickup & (n.blk | mode_blk);
    if (!n.start) begin
      n.presc = '0;
      n.steps = '0;
      n.alarm = 1'b0;
    end else if (!s.alarm) begin
      if (s.steps >= s.delay) begin
        n.alarm = 1'b1;
      end else if (s.presc >= 32'(STEP_CYC - 1)) begin
        n.presc = '0;
        n.steps = s.steps + 19'h0_0001;
      end else begin
        n.presc = s.presc + 32'h0000_0001;
      end
    end
    n.out_alarm   = n.alarm;
    n.out_blocked = n.blocked;
    if (n.force_en & (n.force_sel == ct_pkg::FORCE_ALARM)) begin
      n.out_alarm   = 1'b1;
      n.out_blocked = 1'b0;
    end else if (n.force_en & (n.force_sel == ct_pkg::FORCE_BLOCK)) begin
      n.out_alarm   = 1'b0;
      n.out_blocked = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s       <= '0;
      s.mode  <= ct_pkg::MODE_ON;
      s.behav <= ct_pkg::MODE_ON;
      s.high  <= ct_pkg::RST_HIGH;
      s.low   <= ct_pkg::RST_LOW;
      s.ratio <= ct_pkg::RST_RATIO;
      s.seq   <= ct_pkg::RST_SEQ;
      s.sumd  <= ct_pkg::RST_SUMD;
      s.delay <= ct_pkg::RST_DELAY;
    end else begin
      s <= n;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
  assign avs_readdata    = s.rdata;
  assign alarm           = s.out_alarm;
  assign blocked         = s.out_blocked;
  assign start           = s.start;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wr_ctrl;
    avs_write && !avs_waitrequest && avs_address == ct_pkg::OFF_CTRL;
  endsequence
  sequence s_comp;
    s_wr_ctrl ##0 avs_byteenable[2] && avs_writedata[ct_pkg::CTRL_COMP_BIT];
  endsequence

  property p_behav;
    s_wr_ctrl ##0 avs_byteenable[0]
      |=> ##1 s.behav == $past(avs_writedata[2:0], 2);
  endproperty
  a_behav: assert property (p_behav) else $error("behaviour lags mode");
  property p_off;
    s.mode == ct_pkg::MODE_OFF && !avs_write |=> !s.start && !s.blocked;
  endproperty
  a_off: assert property (p_off) else $error("off mode active");
  property p_force_alarm;
    s.force_en && s.force_sel == ct_pkg::FORCE_ALARM && !avs_write
      |=> alarm && !blocked;
  endproperty
  a_force_alarm: assert property (p_force_alarm) else $error("no forced alarm");
  property p_force_block;
    s.force_en && s.force_sel == ct_pkg::FORCE_BLOCK && !avs_write
      |=> blocked && !alarm;
  endproperty
  a_force_block: assert property (p_force_block) else $error("no forced block");
  property p_comp;
    s_comp |=> s.off_re == $past(calc_re) && s.off_im == $past(calc_im);
  endproperty
  a_comp: assert property (p_comp) else $error("offset not stored");
  property p_high;
    |s.hi_st && !s.bin_sel |-> !pickup;
  endproperty
  a_high: assert property (p_high) else $error("pickup above high limit");
  property p_alarm_time;
    $rose(s.alarm) |-> $past(s.steps) >= $past(s.delay) && s.start;
  endproperty
  a_alarm_time: assert property (p_alarm_time) else $error("alarm too early");
  property p_start_blk;
    s.start |-> !s.blk && !s.blocked;
  endproperty
  a_start_blk: assert property (p_start_blk) else $error("start while blocked");
  property p_bin;
    s.bin_sel && binary_pickup && !s.blk && !meas_valid && !avs_write
      && s.mode == ct_pkg::MODE_ON |=> s.start;
  endproperty
  a_bin: assert property (p_bin) else $error("binary pickup delayed");
  property p_all;
    pickup && !s.bin_sel |-> s.mm_st && s.seq_st && |s.lo_st && !(&s.lo_st);
  endproperty
  a_all: assert property (p_all) else $error("pickup without conditions");
  property p_drop;
    !s.start |-> !s.alarm && s.steps == 19'h0_0000;
  endproperty
  a_drop: assert property (p_drop) else $error("timer not reset");
  property p_bus;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
endmodule
`default_nettype wire

/* ct_meas_model.sv */
// Measurement chain model: one processing-cycle strobe every PER clocks.
// Assumes the bench changes readings only through set_ph and set_vec.
`timescale 1ns/10ps
`default_nettype none
module ct_meas_model #(
  parameter int PER = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  output logic               meas_valid,
  output logic [15:0]        phase_a_rms,
  output logic [15:0]        phase_b_rms,
  output logic [15:0]        phase_c_rms,
  output logic [15:0]        pos_seq,
  output logic [15:0]        neg_seq,
  output logic signed [15:0] calc_re,
  output logic signed [15:0] calc_im,
  output logic signed [16:0] calc_ang,
  output logic signed [15:0] residual_channel_one_re,
  output logic signed [15:0] residual_channel_one_im,
  output logic signed [16:0] residual_channel_one_ang,
  output logic signed [15:0] residual_channel_two_re,
  output logic signed [15:0] residual_channel_two_im,
  output logic signed [16:0] residual_channel_two_ang
);
  int cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt        <= 0;
      meas_valid <= 1'b0;
    end else begin
      cnt        <= (cnt == PER - 1) ? 0 : cnt + 1;
      meas_valid <= (cnt == PER - 1);
    end
  end
  // Readings change only at a strobe, so one cycle never mixes two sets
  task automatic set_ph(input logic [15:0] a, b, c, p, n);
    @(posedge clk iff meas_valid);
    phase_a_rms <= a;
    phase_b_rms <= b;
    phase_c_rms <= c;
    pos_seq     <= p;
    neg_seq     <= n;
  endtask
  task automatic set_vec(input logic signed [15:0] cr, r1, r2,
                         input logic signed [16:0] ca, a1, a2);
    @(posedge clk iff meas_valid);
    calc_re                  <= cr;
    calc_ang                 <= ca;
    residual_channel_one_re  <= r1;
    residual_channel_one_ang <= a1;
    residual_channel_two_re  <= r2;
    residual_channel_two_ang <= a2;
  endtask
  initial begin
    {phase_a_rms, phase_b_rms, phase_c_rms, pos_seq, neg_seq} = '0;
    {calc_re, calc_im, calc_ang} = '0;
    {residual_channel_one_re, residual_channel_one_im} = '0;
    {residual_channel_two_re, residual_channel_two_im} = '0;
    {residual_channel_one_ang, residual_channel_two_ang} = '0;
  end
endmodule
`default_nettype wire

/* ct_circuit_supervision_tb.sv */
// Self-checking bench for the circuit supervision block.
// Assumes a 4-clock delay step; bus waits follow waitrequest alone.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) \
  begin \
    n_checks++; \
    if ((s) !== (e)) begin \
      err_count++; \
      $display("Error %s exp %h seen %h", nm, e, s); \
    end \
  end
module ct_circuit_supervision_tb;
  logic clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic block_in = 1'b0, binary_pickup = 1'b0;
  logic avs_waitrequest, meas_valid, alarm, blocked, start;
  logic [5:0] avs_address = 6'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, d;
  logic [15:0] phase_a_rms, phase_b_rms, phase_c_rms, pos_seq, neg_seq;
  logic signed [15:0] calc_re, calc_im, residual_channel_one_re;
  logic signed [15:0] residual_channel_one_im, residual_channel_two_re;
  logic signed [15:0] residual_channel_two_im;
  logic signed [16:0] calc_ang, residual_channel_one_ang;
  logic signed [16:0] residual_channel_two_ang;
  int err_count = 0, n_checks = 0, seed = 60864;
  logic [63:0] q [$];
  logic [63:0] nt;
  logic [31:0] rv [7] = '{32'h1, 32'h78, 32'hA, 32'h3E8, 32'h1324,
                          32'hA, 32'h64};
  logic [15:0] ca [3] = '{16'h0, 16'h9, 16'h0};
  logic [15:0] cb [3] = '{16'h64, 16'h50, 16'h5};
  logic [15:0] cn [3] = '{16'h1E, 16'h21, 16'h21};
  logic [31:0] fe [3] = '{32'h0, 32'h8, 32'h10};
  logic [31:0] rc [3] = '{32'h41, 32'h141, 32'h81};
  logic [31:0] rm [3] = '{32'h0, 32'hC8, 32'h96};
  logic [31:0] gm [3] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
  logic [31:0] rg [3] = '{32'hEA, 32'hEA, 32'h2DE};
  logic [31:0] rz [3] = '{32'h0, 32'h1000, 32'h1000};

  ct_circuit_supervision #(.STEP_CYC(4)) dut (.*);
  ct_meas_model #(.PER(8)) mdl (.*);

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up;
    if (q.size() != 0)
      err_count++;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Request held until a rising edge samples waitrequest low, then released
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] dt, input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= dt;
    avs_byteenable <= be;
    avs_read       <= !w;
    avs_write      <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] dt);
    bus(1'b1, a, dt, 4'hF);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] m, e);
    q.push_back({m, e});
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic st(input logic [31:0] m, e);
    rd(ct_pkg::OFF_STATUS, m, e);
  endtask
  task automatic ctl(input logic [31:0] dt);
    wr(ct_pkg::OFF_CTRL, dt);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  always @(negedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      nt = q.pop_front();
      `CHK("readdata", nt[31:0], avs_readdata & nt[63:32])
      if (avs_address == ct_pkg::OFF_STATUS)
        `CHK("pins", nt[5:3], {start, blocked, alarm} & nt[37:35])
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      rd(6'(i * 4), 32'hFFFF, rv[i]);
    wr(6'h2C, 32'hFFFF_FFFF);
    rd(6'h2C, 32'hFFFF_FFFF, 32'h0);
    d = $random(seed);
    bus(1'b1, ct_pkg::OFF_LOW, d, 4'h1);
    rd(ct_pkg::OFF_LOW, 32'hFFFF, {24'h0, d[7:0]});
    wr(ct_pkg::OFF_LOW, 32'hA);
    wr(ct_pkg::OFF_DELAY, 32'hA);
    for (int m = 1; m <= 5; m++) begin
      ctl(32'(m));
      st(32'h7, 32'(m));
    end
    ctl(32'h1);
    mdl.set_ph(16'h0, 16'h64, 16'h64, 16'h43, 16'h21);
    cyc(20);
    st(32'h38, 32'h20);
    cyc(60);
    st(32'h38, 32'h28);
    mdl.set_ph(16'h0, 16'h79, 16'h64, 16'h43, 16'h21);
    cyc(20);
    st(32'hB8, 32'h80);
    mdl.set_ph(16'h0, 16'h76, 16'h64, 16'h43, 16'h21);
    cyc(20);
    st(32'hB8, 32'h80);
    mdl.set_ph(16'h0, 16'h74, 16'h64, 16'h43, 16'h21);
    cyc(20);
    st(32'hB8, 32'h20);
    for (int k = 0; k < 3; k++) begin
      mdl.set_ph(ca[k], cb[k], cb[k], 16'h43, cn[k]);
      cyc(20);
      st(32'h20, 32'h0);
    end
    mdl.set_ph(16'h0, 16'h64, 16'h64, 16'h43, 16'h21);
    block_in <= 1'b1;
    cyc(20);
    st(32'h38, 32'h10);
    block_in <= 1'b0;
    cyc(20);
    st(32'h38, 32'h20);
    ctl(32'h2);
    cyc(20);
    st(32'h3F, 32'h12);
    ctl(32'h1);
    mdl.set_ph(16'h64, 16'h64, 16'h64, 16'h64, 16'h0);
    for (int f = 0; f < 3; f++) begin
      ctl(32'h9 | (32'(f) << 4));
      cyc(4);
      st(32'h18, fe[f]);
    end
    ctl(32'h1);
    mdl.set_vec(16'sh64, -16'sh64, 16'sh32, 17'sh4D2, 17'sh3E8, 17'sh1F4);
    cyc(20);
    rd(ct_pkg::OFF_DANG, 32'hFFFF_FFFF, 32'h4D2);
    for (int r = 0; r < 3; r++) begin
      ctl(rc[r]);
      cyc(20);
      rd(ct_pkg::OFF_DMAG, 32'hFFFF, rm[r]);
      rd(ct_pkg::OFF_DANG, gm[r], rg[r]);
      st(32'h1000, rz[r]);
    end
    ctl(32'h0001_0001);
    ctl(32'h41);
    cyc(20);
    rd(ct_pkg::OFF_OFFSET, 32'hFFFF_FFFF, 32'h64);
    rd(ct_pkg::OFF_DMAG, 32'hFFFF, 32'h64);
    rd(ct_pkg::OFF_CTRL, 32'h0001_0000, 32'h0);
    ctl(32'h201);
    binary_pickup <= 1'b1;
    cyc(3);
    st(32'h20, 32'h20);
    binary_pickup <= 1'b0;
    cyc(3);
    st(32'h20, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
